// ==== logic/scf_pkg.sv ====
package scf_pkg;

	// Register byte offsets
	localparam logic [7:0] ADDR_FIFO_CFG = 8'h00;
	localparam logic [7:0] ADDR_RX_FIFO_CTRL = 8'h04;
	localparam logic [7:0] ADDR_MODE_CTRL = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0c;
	localparam logic [7:0] ADDR_TX_DATA = 8'h10;
	localparam logic [7:0] ADDR_RX_DATA = 8'h14;

	// Fifo configuration fields
	localparam int FC_ENABLE = 0;
	localparam int FC_AUTO_DIS = 1;
	localparam int FC_RX_IE = 2;
	localparam int FC_TX_IE = 3;
	localparam int FC_RX_USE_LEVEL = 4;
	localparam int FC_WIDTH = 5;

	// Rx fifo control fields
	localparam int RC_LEVEL_LO = 0;
	localparam int RC_COND = 6;
	localparam int RC_CLEAR = 7;

	// Mode control fields
	localparam int MC_RXE = 0;
	localparam int MC_TXE = 1;
	localparam int MC_DUPLEX_LO = 2;

	// Duplex encodings
	localparam logic [1:0] DPX_HALF_RX = 2'h1;
	localparam logic [1:0] DPX_HALF_TX = 2'h2;
	localparam logic [1:0] DPX_FULL = 2'h3;

	// Depths
	localparam int FIFO_DEPTH = 4;
	localparam logic [2:0] DEPTH_HALF = 3'h4;
	localparam logic [2:0] DEPTH_FULL = 3'h2;
	localparam logic [2:0] DEPTH_NONE = 3'h0;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic [7:0] data;
		logic valid;
	} scf_byte_t;

	typedef struct packed {
		logic rxEnable;
		logic txEnable;
		logic [1:0] duplex;
	} scf_mode_t;

endpackage

// ==== logic/scf_byte_fifo.sv ====
`timescale 1ns/1ps
module scf_byte_fifo (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Control
	input wire logic flush,
	input wire logic [2:0] depth,
	// Write side
	input wire scf_pkg::scf_byte_t wrIn,
	output logic wrReady,
	// Read side
	input wire logic rdTake,
	output scf_pkg::scf_byte_t rdOut,
	output logic [2:0] count
);
	import scf_pkg::*;

	logic [7:0] mem_ff [FIFO_DEPTH];
	logic [7:0] nxt_mem [FIFO_DEPTH];
	logic [1:0] wrPtr_ff, nxt_wrPtr;
	logic [1:0] rdPtr_ff, nxt_rdPtr;
	logic [2:0] count_ff, nxt_count;
	logic doWr, doRd;

	always_comb begin
		wrReady = (count_ff < depth);
		doWr = wrIn.valid && wrReady;
		doRd = rdTake && (count_ff != 3'h0);
		nxt_mem = mem_ff;
		nxt_wrPtr = wrPtr_ff;
		nxt_rdPtr = rdPtr_ff;
		nxt_count = count_ff;
		if (flush) begin
			nxt_wrPtr = 2'h0;
			nxt_rdPtr = 2'h0;
			nxt_count = 3'h0;
		end else begin
			if (doWr) begin
				nxt_mem[wrPtr_ff] = wrIn.data;
				nxt_wrPtr = wrPtr_ff + 2'h1;
			end
			if (doRd) begin
				nxt_rdPtr = rdPtr_ff + 2'h1;
			end
			nxt_count = count_ff + {2'h0, doWr} - {2'h0, doRd};
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			wrPtr_ff <= 2'h0;
			rdPtr_ff <= 2'h0;
			count_ff <= 3'h0;
		end else begin
			wrPtr_ff <= nxt_wrPtr;
			rdPtr_ff <= nxt_rdPtr;
			count_ff <= nxt_count;
		end
		mem_ff <= nxt_mem;
	end

	assign rdOut.data = mem_ff[rdPtr_ff];
	assign rdOut.valid = (count_ff != 3'h0);
	assign count = count_ff;

endmodule

// ==== logic/serial_channel_fifo_config.sv ====
// Implementation choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module serial_channel_fifo_config (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// AXI4-Lite write address
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	// AXI4-Lite write data
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	// AXI4-Lite write response
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Shift engine side
	input wire logic rxShiftFull,
	input wire logic rxBufFull,
	input wire logic rxByteValid,
	input wire logic [7:0] rxByte,
	input wire logic txBufEmpty,
	input wire logic txShiftEmpty,
	input wire logic txByteTake,
	output logic [7:0] txByte,
	output logic txByteValid,
	output logic rxFifoReady,
	// Channel state
	output scf_pkg::scf_mode_t modeOut,
	output logic txIrq,
	output logic rxIrq
);
	import scf_pkg::*;

	// ----------------------------------------
	// Register state
	// ----------------------------------------
	logic [FC_WIDTH-1:0] fcfg_ff, nxt_fcfg;
	logic [1:0] rxLevel_ff, nxt_rxLevel;
	logic rxCond_ff, nxt_rxCond;
	scf_mode_t mode_ff, nxt_mode;
	logic rxFlush_ff, nxt_rxFlush;
	logic txFlush_ff, nxt_txFlush;
	logic txIrq_ff, nxt_txIrq;
	logic rxIrq_ff, nxt_rxIrq;
	logic [7:0] txByte_ff, nxt_txByte;
	logic txByteValid_ff, nxt_txByteValid;
	logic rxFifoReady_ff, nxt_rxFifoReady;

	// ----------------------------------------
	// Bus channel state
	// ----------------------------------------
	logic awHeld_ff, nxt_awHeld;
	logic [7:0] awAddr_ff, nxt_awAddr;
	logic wHeld_ff, nxt_wHeld;
	logic [31:0] wData_ff, nxt_wData;
	logic [3:0] wStrb_ff, nxt_wStrb;
	logic bvalid_ff, nxt_bvalid;
	logic [1:0] bresp_ff, nxt_bresp;
	logic rvalid_ff, nxt_rvalid;
	logic [31:0] rdata_ff, nxt_rdata;
	logic [1:0] rresp_ff, nxt_rresp;
	logic awReady_ff, nxt_awReady;
	logic wReady_ff, nxt_wReady;
	logic arReady_ff, nxt_arReady;

	// ----------------------------------------
	// FIFOs
	// ----------------------------------------
	scf_byte_t rxIn, rxHead, txIn, txHead;
	logic rxWrReady, txWrReady, rxTake, txTake;
	logic [2:0] rxCount, txCount, rxDepth, txDepth, rxThresh;
	logic fifoOn, cfgChange;

	// One-cycle software pops and pushes
	logic swRxPop, swTxPush;
	logic [7:0] swTxData;

	assign fifoOn = fcfg_ff[FC_ENABLE];

	// Resizing with old data inside would misalign pointers
	assign cfgChange = (nxt_fcfg[FC_ENABLE] != fcfg_ff[FC_ENABLE])
		|| (nxt_mode.duplex != mode_ff.duplex);

	always_comb begin
		rxDepth = DEPTH_NONE;
		txDepth = DEPTH_NONE;
		if (fifoOn) begin
			case (mode_ff.duplex)
				DPX_HALF_RX: rxDepth = DEPTH_HALF;
				DPX_HALF_TX: txDepth = DEPTH_HALF;
				DPX_FULL: begin
					rxDepth = DEPTH_FULL;
					txDepth = DEPTH_FULL;
				end
				default: ;
			endcase
		end
		// Fill level decode
		case (rxLevel_ff)
			2'h0: rxThresh = (mode_ff.duplex == DPX_FULL) ? 3'h2 : 3'h4;
			2'h1: rxThresh = 3'h1;
			2'h2: rxThresh = 3'h2;
			default: rxThresh = (mode_ff.duplex == DPX_FULL) ? 3'h1 : 3'h3;
		endcase
	end

	assign rxIn.data = rxByte;
	assign rxIn.valid = rxByteValid && mode_ff.rxEnable && fifoOn;
	assign rxTake = swRxPop;
	assign txIn.data = swTxData;
	assign txIn.valid = swTxPush && fifoOn;
	assign txTake = txByteTake && txByteValid_ff;

	scf_byte_fifo uRxFifo (
		.clk(clk),
		.srst(srst),
		.flush(rxFlush_ff),
		.depth(rxDepth),
		.wrIn(rxIn),
		.wrReady(rxWrReady),
		.rdTake(rxTake),
		.rdOut(rxHead),
		.count(rxCount)
	);

	scf_byte_fifo uTxFifo (
		.clk(clk),
		.srst(srst),
		.flush(txFlush_ff),
		.depth(txDepth),
		.wrIn(txIn),
		.wrReady(txWrReady),
		.rdTake(txTake),
		.rdOut(txHead),
		.count(txCount)
	);

	// ----------------------------------------
	// Bus decode and register updates
	// ----------------------------------------
	logic doWrite, doRead;
	logic [31:0] rdWord;
	logic rdHit;
	logic rxFullCond, txEmptyCond;

	always_comb begin
		nxt_awHeld = awHeld_ff;
		nxt_awAddr = awAddr_ff;
		nxt_wHeld = wHeld_ff;
		nxt_wData = wData_ff;
		nxt_wStrb = wStrb_ff;
		if (awvalid && !awHeld_ff) begin
			nxt_awHeld = 1'b1;
			nxt_awAddr = awaddr;
		end
		if (wvalid && !wHeld_ff) begin
			nxt_wHeld = 1'b1;
			nxt_wData = wdata;
			nxt_wStrb = wstrb;
		end
		doWrite = awHeld_ff && wHeld_ff && !bvalid_ff;
		if (doWrite) begin
			nxt_awHeld = 1'b0;
			nxt_wHeld = 1'b0;
		end
		nxt_bvalid = bvalid_ff;
		nxt_bresp = bresp_ff;
		if (bvalid_ff && bready) begin
			nxt_bvalid = 1'b0;
		end
		doRead = arvalid && !rvalid_ff;
		nxt_rvalid = rvalid_ff;
		nxt_rdata = rdata_ff;
		nxt_rresp = rresp_ff;
		if (rvalid_ff && rready) begin
			nxt_rvalid = 1'b0;
		end

		// Register writes
		nxt_fcfg = fcfg_ff;
		nxt_rxLevel = rxLevel_ff;
		nxt_rxCond = rxCond_ff;
		nxt_mode = mode_ff;
		nxt_rxFlush = 1'b0;
		nxt_txFlush = 1'b0;
		swTxPush = 1'b0;
		swTxData = wData_ff[7:0];
		if (doWrite) begin
			nxt_bvalid = 1'b1;
			nxt_bresp = RESP_OKAY;
			if (awAddr_ff == ADDR_FIFO_CFG) begin
				if (wStrb_ff[0]) nxt_fcfg = wData_ff[FC_WIDTH-1:0];
			end else if (awAddr_ff == ADDR_RX_FIFO_CTRL) begin
				if (wStrb_ff[0]) begin
					nxt_rxLevel = wData_ff[RC_LEVEL_LO +: 2];
					nxt_rxCond = wData_ff[RC_COND];
					nxt_rxFlush = wData_ff[RC_CLEAR];
				end
			end else if (awAddr_ff == ADDR_MODE_CTRL) begin
				if (wStrb_ff[0]) begin
					nxt_mode.rxEnable = wData_ff[MC_RXE];
					nxt_mode.txEnable = wData_ff[MC_TXE];
					nxt_mode.duplex = wData_ff[MC_DUPLEX_LO +: 2];
				end
			end else if (awAddr_ff == ADDR_TX_DATA) begin
				swTxPush = wStrb_ff[0];
			end else if (awAddr_ff == ADDR_STATUS || awAddr_ff == ADDR_RX_DATA) begin
				nxt_bresp = RESP_OKAY;
			end else begin
				nxt_bresp = RESP_SLVERR;
			end
		end

		// Auto-disable of the directions
		rxFullCond = rxShiftFull && rxBufFull && (rxCount == rxDepth) && fifoOn;
		txEmptyCond = (txCount == 3'h0) && txBufEmpty && txShiftEmpty && fifoOn;
		if (fcfg_ff[FC_AUTO_DIS]) begin
			if (mode_ff.duplex == DPX_FULL && mode_ff.rxEnable && mode_ff.txEnable) begin
				if (rxFullCond || txEmptyCond) begin
					nxt_mode.rxEnable = 1'b0;
					nxt_mode.txEnable = 1'b0;
				end
			end else begin
				if (rxFullCond) nxt_mode.rxEnable = 1'b0;
				if (txEmptyCond && mode_ff.txEnable) nxt_mode.txEnable = 1'b0;
			end
		end
		if (cfgChange) begin
			nxt_rxFlush = 1'b1;
			nxt_txFlush = 1'b1;
		end

		// Register reads
		rdHit = 1'b1;
		rdWord = 32'h0000_0000;
		swRxPop = 1'b0;
		if (araddr == ADDR_FIFO_CFG) begin
			rdWord[FC_WIDTH-1:0] = fcfg_ff;
		end else if (araddr == ADDR_RX_FIFO_CTRL) begin
			rdWord[RC_LEVEL_LO +: 2] = rxLevel_ff;
			rdWord[RC_COND] = rxCond_ff;
		end else if (araddr == ADDR_MODE_CTRL) begin
			rdWord[MC_RXE] = mode_ff.rxEnable;
			rdWord[MC_TXE] = mode_ff.txEnable;
			rdWord[MC_DUPLEX_LO +: 2] = mode_ff.duplex;
		end else if (araddr == ADDR_STATUS) begin
			rdWord[2:0] = rxCount;
			rdWord[6:4] = txCount;
		end else if (araddr == ADDR_RX_DATA) begin
			rdWord[7:0] = rxHead.data;
			rdWord[8] = rxHead.valid;
			swRxPop = doRead && rxHead.valid;
		end else if (araddr == ADDR_TX_DATA) begin
			rdWord = 32'h0000_0000;
		end else begin
			rdHit = 1'b0;
		end
		if (doRead) begin
			nxt_rvalid = 1'b1;
			nxt_rdata = rdWord;
			nxt_rresp = rdHit ? RESP_OKAY : RESP_SLVERR;
		end
		nxt_awReady = !nxt_awHeld;
		nxt_wReady = !nxt_wHeld;
		nxt_arReady = !nxt_rvalid;
	end

	// ----------------------------------------
	// Interrupts and engine outputs
	// ----------------------------------------
	logic rxReached;

	always_comb begin
		// Level reached as the byte lands, or still above it at a read
		rxReached = rxIn.valid && rxWrReady && ((rxCount + 3'h1) == rxThresh);
		nxt_rxIrq = fifoOn && fcfg_ff[FC_RX_IE]
			&& (rxReached || (rxCond_ff && swRxPop && (rxCount > rxThresh)));
		nxt_txIrq = fifoOn && fcfg_ff[FC_TX_IE] && txTake;
		nxt_txByteValid = txHead.valid && mode_ff.txEnable && !txFlush_ff && !txTake;
		nxt_txByte = txHead.data;
		nxt_rxFifoReady = rxWrReady && fifoOn;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			fcfg_ff <= '0;
			rxLevel_ff <= 2'h0;
			rxCond_ff <= 1'b0;
			mode_ff <= '0;
			rxFlush_ff <= 1'b0;
			txFlush_ff <= 1'b0;
			txIrq_ff <= 1'b0;
			rxIrq_ff <= 1'b0;
			txByte_ff <= 8'h00;
			txByteValid_ff <= 1'b0;
			rxFifoReady_ff <= 1'b0;
			awHeld_ff <= 1'b0;
			awAddr_ff <= 8'h00;
			wHeld_ff <= 1'b0;
			wData_ff <= 32'h0000_0000;
			wStrb_ff <= 4'h0;
			bvalid_ff <= 1'b0;
			bresp_ff <= RESP_OKAY;
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h0000_0000;
			rresp_ff <= RESP_OKAY;
			awReady_ff <= 1'b1;
			wReady_ff <= 1'b1;
			arReady_ff <= 1'b1;
		end else begin
			fcfg_ff <= nxt_fcfg;
			rxLevel_ff <= nxt_rxLevel;
			rxCond_ff <= nxt_rxCond;
			mode_ff <= nxt_mode;
			rxFlush_ff <= nxt_rxFlush;
			txFlush_ff <= nxt_txFlush;
			txIrq_ff <= nxt_txIrq;
			rxIrq_ff <= nxt_rxIrq;
			txByte_ff <= nxt_txByte;
			txByteValid_ff <= nxt_txByteValid;
			rxFifoReady_ff <= nxt_rxFifoReady;
			awHeld_ff <= nxt_awHeld;
			awAddr_ff <= nxt_awAddr;
			wHeld_ff <= nxt_wHeld;
			wData_ff <= nxt_wData;
			wStrb_ff <= nxt_wStrb;
			bvalid_ff <= nxt_bvalid;
			bresp_ff <= nxt_bresp;
			rvalid_ff <= nxt_rvalid;
			rdata_ff <= nxt_rdata;
			rresp_ff <= nxt_rresp;
			awReady_ff <= nxt_awReady;
			wReady_ff <= nxt_wReady;
			arReady_ff <= nxt_arReady;
		end
	end

	// Write readies are registered copies of the inverted holding flags; arready is a registered copy of inverted rvalid
	assign awready = awReady_ff;
	assign wready = wReady_ff;
	assign arready = arReady_ff;
	assign bvalid = bvalid_ff;
	assign bresp = bresp_ff;
	assign rvalid = rvalid_ff;
	assign rdata = rdata_ff;
	assign rresp = rresp_ff;
	assign txByte = txByte_ff;
	assign txByteValid = txByteValid_ff;
	assign rxFifoReady = rxFifoReady_ff;
	assign modeOut = mode_ff;
	assign txIrq = txIrq_ff;
	assign rxIrq = rxIrq_ff;

endmodule

// ==== bench/scf_monitor.sv ====
`timescale 1ns/1ps
// ----
// Port checks
// ----
module scf_monitor (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Bus
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic rvalid,
	input wire logic rready,
	// Engine and state
	input wire logic txByteTake,
	input wire logic txByteValid,
	input wire scf_pkg::scf_mode_t modeOut,
	input wire logic txIrq,
	input wire logic rxIrq
);
	import scf_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	a_bresp_holds: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write answer dropped");
	a_rresp_holds: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read answer dropped");
	a_read_answer: assert property (arvalid && arready |=> rvalid)
		else $error("read not answered");
	a_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
		else $error("write not answered");
	a_txirq_cause: assert property (txIrq |-> $past(txByteTake && txByteValid))
		else $error("tx irq without take");
	a_txirq_pulse: assert property (txIrq |=> !txIrq)
		else $error("tx irq too long");
	a_rxirq_pulse: assert property (rxIrq |=> !rxIrq)
		else $error("rx irq too long");
	a_take_drops: assert property (txByteTake && txByteValid |=> !txByteValid)
		else $error("tx head kept after take");
	c_tx_irq: cover property (txIrq);
	c_rx_irq: cover property (rxIrq);
	c_rx_off: cover property ($fell(modeOut.rxEnable));
endmodule
bind serial_channel_fifo_config scf_monitor mon (.clk, .srst, .awvalid, .awready, .wvalid, .wready,
	.bresp, .bvalid, .bready, .arvalid, .arready, .rdata, .rvalid, .rready, .txByteTake,
	.txByteValid, .modeOut, .txIrq, .rxIrq);

// ==== bench/scf_engine_model.sv ====
`timescale 1ns/1ps
// ----
// Serial engine stand-in
// ----
module scf_engine_model (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Bench control
	input wire logic sendReq,
	input wire logic [7:0] sendData,
	input wire logic fullOn,
	input wire logic takeOn,
	// Device side
	input wire logic txByteValid,
	output logic rxShiftFull,
	output logic rxBufFull,
	output logic rxByteValid,
	output logic [7:0] rxByte,
	output logic txBufEmpty,
	output logic txShiftEmpty,
	output logic txByteTake
);
	logic [1:0] busy_ff;
	// Shifter stays busy after a take, so empty is never instant
	always_ff @(posedge clk) begin
		if (srst) begin
			busy_ff <= 2'h0;
			rxByteValid <= 1'b0;
			rxByte <= 8'h00;
			txByteTake <= 1'b0;
		end else begin
			rxByteValid <= sendReq;
			// Idle data toggles so a stale byte never looks good
			rxByte <= sendReq ? sendData : ~rxByte;
			txByteTake <= takeOn && txByteValid && !txByteTake && busy_ff == 2'h0;
			busy_ff <= txByteTake ? 2'h3 : (busy_ff != 2'h0 ? busy_ff - 2'h1 : 2'h0);
		end
	end
	assign rxShiftFull = fullOn;
	assign rxBufFull = fullOn;
	assign txBufEmpty = busy_ff == 2'h0 && !txByteTake;
	assign txShiftEmpty = txBufEmpty;
endmodule

// ==== bench/serial_channel_fifo_config_tb.sv ====
`timescale 1ns/1ps
module serial_channel_fifo_config_tb;
	import scf_pkg::*;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic sendReq = 1'b0;
	logic [7:0] sendData = 8'h00;
	logic fullOn = 1'b0;
	logic takeOn = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, rxShiftFull, rxBufFull, rxByteValid;
	logic txBufEmpty, txShiftEmpty, txByteTake, txByteValid, rxFifoReady, txIrq, rxIrq;
	logic [1:0] bresp, rresp, rsp;
	logic [31:0] rdata, rv;
	logic [7:0] rxByte, txByte, lastTx, pushed;
	scf_mode_t modeOut;
	int miscompares = 0, comparisons = 0, cyc = 0, rxN = 0, txN = 0, takeN = 0, n0, t0;
	integer seed = 32'ha0dd;
	always #10 clk = ~clk;
	serial_channel_fifo_config uut (.clk, .srst, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hf),
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
		.rvalid, .rready, .rxShiftFull, .rxBufFull, .rxByteValid, .rxByte, .txBufEmpty,
		.txShiftEmpty, .txByteTake, .txByte, .txByteValid, .rxFifoReady, .modeOut, .txIrq, .rxIrq);
	scf_engine_model eng (.clk, .srst, .sendReq, .sendData, .fullOn, .takeOn, .txByteValid,
		.rxShiftFull, .rxBufFull, .rxByteValid, .rxByte, .txBufEmpty, .txShiftEmpty, .txByteTake);
	// ----
	// Event counters and hang guard
	// ----
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (rxIrq === 1'b1) rxN <= rxN + 1;
		if (txIrq === 1'b1) txN <= txN + 1;
		if (txByteTake === 1'b1 && txByteValid === 1'b1) begin
			takeN <= takeN + 1;
			lastTx <= txByte;
		end
		if (cyc == 20000) begin
			miscompares++;
			close_out;
		end
	end
	task automatic close_out;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			miscompares++;
			$display("ERROR %s exp %h seen %h", nm, e, s);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		rsp = bresp;
		bready <= 1'b0;
		// One edge apart, so a following call never re-drives bready in this step
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rv = rdata;
		rsp = rresp;
		rready <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
		rd(a);
		chk(nm, rv, e);
	endtask
	task automatic send(input int n);
		repeat (n) begin
			sendReq <= 1'b1;
			sendData <= 8'($random(seed));
			@(posedge clk);
			sendReq <= 1'b0;
			tick(3);
		end
	endtask
	// Fill level for a code, half or full duplex
	function automatic int lvl(input bit fd, input bit [1:0] c);
		return fd ? (c[0] ? 1 : 2) : (c == 2'h0 ? 4 : int'(c));
	endfunction
	// ----
	// Main sequence
	// ----
	initial begin
		tick(6);
		srst <= 1'b0;
		@(posedge clk);
		rc("cfg", ADDR_FIFO_CFG, 0);
		rc("rxctl", ADDR_RX_FIFO_CTRL, 0);
		rd(8'h18);
		chk("rresp", rsp, RESP_SLVERR);
		wr(8'h1c, 1);
		chk("bresp", rsp, RESP_SLVERR);
		$display("test reset done");
		wr(ADDR_MODE_CTRL, 32'h5);
		send(2);
		rc("bypass", ADDR_STATUS, 0);
		chk("rdyoff", rxFifoReady, 0);
		for (int fd = 0; fd < 2; fd++) begin
			wr(ADDR_MODE_CTRL, fd ? 32'hf : 32'h5);
			// Eight-bit frames only and no DMA pacing, so the FIFO may be on
			wr(ADDR_FIFO_CFG, 1);
			wr(ADDR_RX_FIFO_CTRL, 32'h80);
			send(6);
			rc("depth", ADDR_STATUS, fd ? 2 : 4);
		end
		wr(ADDR_MODE_CTRL, 32'h5);
		rc("flush", ADDR_STATUS, 0);
		chk("rdyon", rxFifoReady, 1);
		send(1);
		rc("rxdata", ADDR_RX_DATA, {23'h0, 1'b1, sendData});
		send(3);
		wr(ADDR_RX_FIFO_CTRL, 32'h80);
		rc("clear", ADDR_STATUS, 0);
		rc("clrbit", ADDR_RX_FIFO_CTRL, 0);
		$display("test depth done");
		for (int fd = 0; fd < 2; fd++)
			for (int c = 0; c < 4; c++)
				for (int ie = 0; ie < 2; ie++) begin
					wr(ADDR_MODE_CTRL, fd ? 32'hf : 32'h5);
					wr(ADDR_FIFO_CFG, ie ? 32'h5 : 32'h1);
					wr(ADDR_RX_FIFO_CTRL, 32'h80 | c);
					n0 = rxN;
					send(lvl(fd, c) - 1);
					chk("early", rxN - n0, 0);
					send(1);
					chk("rxirq", rxN - n0, ie);
				end
		for (int cnd = 0; cnd < 2; cnd++) begin
			wr(ADDR_RX_FIFO_CTRL, 32'h81 | cnd << 6);
			send(3);
			n0 = rxN;
			rd(ADDR_RX_DATA);
			tick(3);
			chk("again", rxN - n0, cnd);
		end
		$display("test rx irq done");
		for (int ad = 0; ad < 2; ad++) begin
			wr(ADDR_FIFO_CFG, ad ? 32'h3 : 32'h9);
			wr(ADDR_MODE_CTRL, 32'h8);
			for (int i = 0; i < 3; i++) begin
				pushed = 8'($random(seed));
				wr(ADDR_TX_DATA, {24'h0, pushed});
			end
			rc("txcnt", ADDR_STATUS, 32'h30);
			n0 = txN;
			t0 = takeN;
			wr(ADDR_MODE_CTRL, 32'ha);
			takeOn <= 1'b1;
			tick(30);
			takeOn <= 1'b0;
			chk("takes", takeN - t0, 3);
			chk("txirq", txN - n0, ad ? 0 : 3);
			chk("lasttx", lastTx, pushed);
			chk("txe", modeOut.txEnable, !ad);
		end
		$display("test tx done");
		wr(ADDR_FIFO_CFG, 32'h3);
		wr(ADDR_MODE_CTRL, 32'h5);
		send(5);
		chk("rxe", modeOut.rxEnable, 1);
		fullOn <= 1'b1;
		tick(3);
		chk("rxoff", modeOut.rxEnable, 0);
		fullOn <= 1'b0;
		wr(ADDR_MODE_CTRL, 32'hc);
		wr(ADDR_TX_DATA, 32'h5a);
		wr(ADDR_MODE_CTRL, 32'hf);
		send(3);
		chk("both", modeOut.txEnable && modeOut.rxEnable, 1);
		fullOn <= 1'b1;
		tick(3);
		chk("bothoff", modeOut.txEnable || modeOut.rxEnable, 0);
		fullOn <= 1'b0;
		$display("test auto off done");
		close_out;
	end
endmodule
